// >>> rtl/cit_instruction_timing.sv
// Instruction decode, cycle timing, branch targets, data pointer and stack pointer
`timescale 1ns/100ps

module cit_instruction_timing
	import cit_pkg::*;
(
	input wire logic clock, // System clock, 25 MHz
	input wire logic rst_b, // Asynchronous reset, active low
	input wire logic instr_valid, // Instruction bytes present
	input wire cit_instr_type instr, // Opcode and operand bytes
	output logic instr_ready, // Instruction taken this cycle when valid
	input wire logic [7:0] acc_value, // Accumulator contents
	input wire logic carry_flag, // Carry flag
	input wire logic bit_value, // Addressed direct bit
	input wire logic [7:0] operand_value, // Fetched register, direct or indirect byte
	input wire logic [1:0] bank_select, // Selected register bank
	input wire logic [15:0] return_addr, // Address popped for returns
	input wire logic sfr_wr, // Special register write strobe
	input wire logic [7:0] sfr_addr, // Special register address
	input wire logic [7:0] sfr_wdata, // Special register write data
	output logic [7:0] sfr_rdata, // Special register read data
	output logic [4:0] reg_addr, // Bank register address for the operand
	output logic dir_is_sfr, // Direct operand selects a special register
	output logic [6:0] ram_addr, // Direct operand data RAM address
	output logic [15:0] fetch_addr, // Address of the next instruction
	output logic done, // Instruction retired
	output logic branch_taken, // Branch condition of the last accepted instruction
	output cit_mem_type mem_req, // Code or external data access
	output logic stack_wr, // Stack write strobe
	output logic stack_rd, // Stack read strobe
	output logic [7:0] stack_addr, // Stack access address
	output logic [7:0] stack_pointer, // Stack pointer
	output logic bit_clear, // Clear the tested direct bit
	output logic [7:0] dec_result, // Decremented byte for write-back
	output logic [7:0] nibble_ram, // Byte to store back after nibble exchange
	output logic [7:0] nibble_acc, // Accumulator after nibble exchange
	output logic [15:0] wide_pointer // Combined pointer value
);
	logic rst_meta_reg, rst_sync_reg;
	logic busy_reg, done_reg, taken_reg, bit_clear_reg, stack_wr_reg, stack_rd_reg;
	logic [2:0] cnt_reg;
	logic [15:0] pc_reg;
	logic [7:0] sp_reg, sp_next, ptr_low_reg, ptr_high_reg, stack_addr_reg, sfr_rdata_reg;
	logic [7:0] dec_result_reg, nibble_ram_reg, nibble_acc_reg, rel;
	cit_mem_type mem_reg;
	cit_decode_type dec;
	logic accept, taken;
	logic [15:0] seq_pc, rel_pc, target;

	// Reset release through two flip-flops
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// Decode and handshake; a new instruction may enter in the last cycle of the old one
	assign dec = cit_decode(instr.opcode);
	assign instr_ready = !busy_reg || (cnt_reg == CYCLE_LAST);
	assign accept = instr_valid && instr_ready;

	// Operand addressing
	assign reg_addr = instr.opcode[REG_FORM_BIT] ? {bank_select, instr.opcode[2:0]}
		: {bank_select, 2'b00, instr.opcode[0]};
	assign dir_is_sfr = instr.op1[DIRECT_SFR_BIT];
	assign ram_addr = instr.op1[DIRECT_SFR_BIT-1:0];

	// Branch condition of the offered instruction
	always_comb
	begin
		taken = 1'b0;
		casez (instr.opcode)
			OP_JUMP_CARRY: taken = carry_flag;
			OP_JUMP_NO_CARRY: taken = !carry_flag;
			OP_JUMP_ZERO: taken = (acc_value == 8'h00);
			OP_JUMP_NONZERO: taken = (acc_value != 8'h00);
			OP_JUMP_BIT, OP_BIT_TEST_CLEAR: taken = bit_value;
			OP_JUMP_NO_BIT: taken = !bit_value;
			OP_CMP_ACC_IMM: taken = (acc_value != instr.op1);
			OP_CMP_ACC_DIRECT: taken = (acc_value != operand_value);
			OP_CMP_IND_IMM0, OP_CMP_IND_IMM1, OP_CMP_REG_IMM:
				taken = (operand_value != instr.op1);
			OP_DEC_REG, OP_DEC_DIRECT: taken = (operand_value != 8'h01);
			default: taken = 1'b0;
		endcase
	end

	// Next program counter
	assign rel = (dec.len == LEN_THREE) ? instr.op2 : instr.op1;
	assign seq_pc = pc_reg + {14'h0000, dec.len};
	assign rel_pc = seq_pc + {{8{rel[7]}}, rel};
	always_comb
	begin
		case (dec.cls)
			CL_COND: target = taken ? rel_pc : seq_pc;
			CL_SHORT: target = rel_pc;
			CL_PAGE_JUMP, CL_PAGE_CALL:
				target = {seq_pc[PC_MSB:PAGE_LSB], instr.opcode[PAGE_OPC_MSB:PAGE_OPC_LSB],
					instr.op1};
			CL_FAR_JUMP, CL_FAR_CALL: target = {instr.op1, instr.op2};
			CL_RETURN: target = return_addr;
			CL_PTR_JUMP: target = {ptr_high_reg, ptr_low_reg} + {8'h00, acc_value};
			default: target = seq_pc;
		endcase
	end

	// Cycle counter: not-taken count from the table, one more when taken
	always_ff @(posedge clock or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
		begin
			busy_reg <= 1'b0;
			cnt_reg <= 3'h0;
			done_reg <= 1'b0;
			taken_reg <= 1'b0;
		end
		else
		begin
			done_reg <= busy_reg && (cnt_reg == CYCLE_LAST);
			if (accept)
			begin
				busy_reg <= 1'b1;
				cnt_reg <= dec.cyc + {2'b00, taken};
				taken_reg <= taken;
			end
			else if (busy_reg)
			begin
				cnt_reg <= cnt_reg - CYCLE_LAST;
				if (cnt_reg == CYCLE_LAST)
					busy_reg <= 1'b0;
			end
		end
	end

	// Program counter moves on when the instruction is taken
	always_ff @(posedge clock or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
			pc_reg <= PC_RESET;
		else if (accept)
			pc_reg <= target;
	end

	// Wide pointer bytes: constant load or special register write
	always_ff @(posedge clock or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
		begin
			ptr_low_reg <= POINTER_RESET;
			ptr_high_reg <= POINTER_RESET;
		end
		else if (accept && dec.cls == CL_LOAD_PTR)
		begin
			ptr_high_reg <= instr.op1;
			ptr_low_reg <= instr.op2;
		end
		else if (sfr_wr)
		begin
			if (sfr_addr == ADDR_PTR_LOW)
				ptr_low_reg <= sfr_wdata;
			if (sfr_addr == ADDR_PTR_HIGH)
				ptr_high_reg <= sfr_wdata;
		end
	end

	// Stack pointer steps; push increments first, then stores at the new value
	always_comb
	begin
		case (dec.cls)
			CL_PUSH: sp_next = sp_reg + 8'h01;
			CL_FAR_CALL, CL_PAGE_CALL: sp_next = sp_reg + 8'h02;
			CL_POP: sp_next = sp_reg - 8'h01;
			CL_RETURN: sp_next = sp_reg - 8'h02;
			default: sp_next = sp_reg;
		endcase
	end
	always_ff @(posedge clock or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
		begin
			sp_reg <= STACK_RESET;
			stack_wr_reg <= 1'b0;
			stack_rd_reg <= 1'b0;
			stack_addr_reg <= STACK_RESET;
		end
		else
		begin
			stack_wr_reg <= accept && (dec.cls == CL_PUSH);
			stack_rd_reg <= accept && (dec.cls == CL_POP);
			if (accept)
			begin
				sp_reg <= sp_next;
				stack_addr_reg <= (dec.cls == CL_PUSH) ? sp_next : sp_reg;
			end
			else if (sfr_wr && sfr_addr == ADDR_STACK)
				sp_reg <= sfr_wdata;
		end
	end

	// Memory requests for code reads and external data moves, one cycle each
	always_ff @(posedge clock or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
			mem_reg <= '0;
		else
		begin
			mem_reg <= '0;
			if (accept && dec.cls == CL_CODE_READ)
			begin
				mem_reg.code_rd <= 1'b1;
				mem_reg.addr <= ((instr.opcode == OP_CODE_READ_PTR) ?
					{ptr_high_reg, ptr_low_reg} : seq_pc) + {8'h00, acc_value};
			end
			if (accept && dec.cls == CL_EXT_MOVE)
			begin
				mem_reg.xdata_rd <= !instr.opcode[4];
				mem_reg.xdata_wr <= instr.opcode[4];
				mem_reg.addr <= instr.opcode[1] ? {8'h00, operand_value}
					: {ptr_high_reg, ptr_low_reg};
			end
		end
	end

	// Data results: bit clear, decrement, nibble exchange, register readback
	always_ff @(posedge clock or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
		begin
			bit_clear_reg <= 1'b0;
			dec_result_reg <= 8'h00;
			nibble_ram_reg <= 8'h00;
			nibble_acc_reg <= 8'h00;
			sfr_rdata_reg <= 8'h00;
		end
		else
		begin
			bit_clear_reg <= accept && (instr.opcode == OP_BIT_TEST_CLEAR) && taken;
			if (accept && (dec.cls == CL_COND))
				dec_result_reg <= operand_value - 8'h01;
			if (accept && dec.cls == CL_NIBBLE)
			begin
				nibble_ram_reg <= {operand_value[7:4], acc_value[3:0]};
				nibble_acc_reg <= {acc_value[7:4], operand_value[3:0]};
			end
			case (sfr_addr)
				ADDR_PTR_LOW: sfr_rdata_reg <= ptr_low_reg;
				ADDR_PTR_HIGH: sfr_rdata_reg <= ptr_high_reg;
				ADDR_STACK: sfr_rdata_reg <= sp_reg;
				default: sfr_rdata_reg <= 8'h00;
			endcase
		end
	end

	// Output drive
	assign sfr_rdata = sfr_rdata_reg;
	assign fetch_addr = pc_reg;
	assign done = done_reg;
	assign branch_taken = taken_reg;
	assign mem_req = mem_reg;
	assign stack_wr = stack_wr_reg;
	assign stack_rd = stack_rd_reg;
	assign stack_addr = stack_addr_reg;
	assign stack_pointer = sp_reg;
	assign bit_clear = bit_clear_reg;
	assign dec_result = dec_result_reg;
	assign nibble_ram = nibble_ram_reg;
	assign nibble_acc = nibble_acc_reg;
	assign wide_pointer = {ptr_high_reg, ptr_low_reg};

	// Checks: an N-cycle instruction retires N+1 sampled edges after it is taken
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_sync_reg);

	a_unused_like_nop: assert property ((accept && instr.opcode == OP_UNUSED)
		|=> pc_reg == $past(pc_reg) + 16'h0001 ##1 done) else $error("unused opcode timing");
	a_code_read_time: assert property ((accept && dec.cls == CL_CODE_READ)
		|=> mem_req.code_rd ##3 done) else $error("code read timing");
	a_ext_short_addr: assert property ((accept && dec.cls == CL_EXT_MOVE && instr.opcode[1])
		|=> mem_req.addr[15:8] == 8'h00 ##3 done) else $error("external move timing");
	a_carry_jump_time: assert property ((accept && instr.opcode == OP_JUMP_CARRY)
		|-> if (carry_flag) ##4 done else ##3 done) else $error("carry jump timing");
	a_test_clear_bit: assert property ((accept && instr.opcode == OP_BIT_TEST_CLEAR
		&& bit_value) |=> bit_clear ##4 done) else $error("test and clear timing");
	a_compare_direct: assert property ((accept && instr.opcode == OP_CMP_ACC_DIRECT
		&& acc_value == operand_value) |-> ##5 done) else $error("compare timing");
	a_far_target: assert property ((accept && dec.cls == CL_FAR_JUMP)
		|=> pc_reg == {$past(instr.op1), $past(instr.op2)} ##4 done) else $error("far jump");
	a_page_target: assert property ((accept && dec.cls == CL_PAGE_JUMP)
		|=> pc_reg[PC_MSB:PAGE_LSB] == $past(seq_pc[PC_MSB:PAGE_LSB])) else $error("page jump");
	a_rel_target: assert property ((accept && dec.cls == CL_SHORT)
		|=> pc_reg == $past(rel_pc) ##3 done) else $error("short jump target");
	a_push_pre_inc: assert property ((accept && dec.cls == CL_PUSH)
		|=> stack_wr && stack_addr == $past(sp_reg) + 8'h01) else $error("push order");

	// Pop strobe, pointer load, data results and handshake while busy
	a_pop_strobe: assert property ((accept && dec.cls == CL_POP)
		|=> stack_rd && stack_addr == $past(sp_reg) ##2 done) else $error("pop timing");
	a_pointer_load: assert property ((accept && dec.cls == CL_LOAD_PTR)
		|=> wide_pointer == {$past(instr.op1), $past(instr.op2)} ##3 done)
		else $error("pointer load");
	a_nibble_swap: assert property ((accept && dec.cls == CL_NIBBLE)
		|=> nibble_acc == {$past(acc_value[7:4]), $past(operand_value[3:0])} ##2 done)
		else $error("nibble exchange");
	a_dec_write_back: assert property ((accept && instr.opcode == OP_DEC_DIRECT)
		|=> dec_result == $past(operand_value) - 8'h01) else $error("decrement result");
	a_ready_while_busy: assert property ((accept && dec.cls == CL_RETURN)
		|=> !instr_ready [*4] ##1 instr_ready) else $error("return handshake");

	c_taken_branch: cover property (accept && dec.cls == CL_COND && taken);
	c_back_to_back: cover property (accept && busy_reg);
	c_return: cover property (accept && dec.cls == CL_RETURN ##6 done);
	c_ext_write: cover property (accept && dec.cls == CL_EXT_MOVE && instr.opcode[4]);
endmodule

// >>> rtl/cit_pkg.sv
// Opcodes, decode table, register addresses and carrier types for the instruction timing unit
package cit_pkg;
	// Opcodes with fixed encodings
	localparam logic [7:0] OP_NOP = 8'h00;
	localparam logic [7:0] OP_UNUSED = 8'ha5;
	localparam logic [7:0] OP_FAR_JUMP = 8'h02;
	localparam logic [7:0] OP_FAR_CALL = 8'h12;
	localparam logic [7:0] OP_SUB_RETURN = 8'h22;
	localparam logic [7:0] OP_INT_RETURN = 8'h32;
	localparam logic [7:0] OP_SHORT_JUMP = 8'h80;
	localparam logic [7:0] OP_PTR_JUMP = 8'h73;
	localparam logic [7:0] OP_JUMP_CARRY = 8'h40;
	localparam logic [7:0] OP_JUMP_NO_CARRY = 8'h50;
	localparam logic [7:0] OP_JUMP_ZERO = 8'h60;
	localparam logic [7:0] OP_JUMP_NONZERO = 8'h70;
	localparam logic [7:0] OP_JUMP_BIT = 8'h20;
	localparam logic [7:0] OP_JUMP_NO_BIT = 8'h30;
	localparam logic [7:0] OP_BIT_TEST_CLEAR = 8'h10;
	localparam logic [7:0] OP_CMP_ACC_DIRECT = 8'hb5;
	localparam logic [7:0] OP_CMP_ACC_IMM = 8'hb4;
	localparam logic [7:0] OP_CMP_IND_IMM0 = 8'hb6;
	localparam logic [7:0] OP_CMP_IND_IMM1 = 8'hb7;
	localparam logic [7:0] OP_DEC_DIRECT = 8'hd5;
	localparam logic [7:0] OP_CODE_READ_PTR = 8'h93;
	localparam logic [7:0] OP_CODE_READ_PC = 8'h83;
	localparam logic [7:0] OP_XRD_PTR = 8'he0;
	localparam logic [7:0] OP_XWR_PTR = 8'hf0;
	localparam logic [7:0] OP_XRD_IND0 = 8'he2;
	localparam logic [7:0] OP_XRD_IND1 = 8'he3;
	localparam logic [7:0] OP_XWR_IND0 = 8'hf2;
	localparam logic [7:0] OP_XWR_IND1 = 8'hf3;
	localparam logic [7:0] OP_LOAD_POINTER = 8'h90;
	localparam logic [7:0] OP_MOVE_DIR_DIR = 8'h85;
	localparam logic [7:0] OP_PUSH = 8'hc0;
	localparam logic [7:0] OP_POP = 8'hd0;
	localparam logic [7:0] OP_NIBBLE_X0 = 8'hd6;
	localparam logic [7:0] OP_NIBBLE_X1 = 8'hd7;
	// Opcode families matched with don't-care bits, and the fixed OP_BIT_OR
	localparam logic [7:0] OP_PAGE_JUMP = 8'b???0_0001;
	localparam logic [7:0] OP_PAGE_CALL = 8'b???1_0001;
	localparam logic [7:0] OP_CMP_REG_IMM = 8'b1011_1???;
	localparam logic [7:0] OP_DEC_REG = 8'b1101_1???;
	localparam logic [7:0] OP_ACC_SINGLE = 8'b????_0100;
	localparam logic [7:0] OP_IND_ACC_MOVE = 8'b111?_011?;
	localparam logic [7:0] OP_CARRY_SINGLE = 8'b1??1_0011;
	localparam logic [7:0] OP_BIT_OP = 8'b1???_0010;
	localparam logic [7:0] OP_BIT_OR = 8'h72;
	localparam logic [7:0] OP_ROTATE = 8'b00??_0011;
	// Special register addresses and reset values
	localparam logic [7:0] ADDR_STACK = 8'h81;
	localparam logic [7:0] ADDR_PTR_LOW = 8'h82;
	localparam logic [7:0] ADDR_PTR_HIGH = 8'h83;
	localparam logic [7:0] STACK_RESET = 8'h07;
	localparam logic [7:0] POINTER_RESET = 8'h00;
	localparam logic [15:0] PC_RESET = 16'h0000;
	// Field positions, last-cycle counter value and byte lengths
	localparam int DIRECT_SFR_BIT = 7;
	localparam int PC_MSB = 15;
	localparam int PAGE_LSB = 11;
	localparam int PAGE_OPC_MSB = 7;
	localparam int PAGE_OPC_LSB = 5;
	localparam int REG_FORM_BIT = 3;
	localparam logic [2:0] CYCLE_LAST = 3'h1;
	localparam logic [1:0] LEN_ONE = 2'h1;
	localparam logic [1:0] LEN_TWO = 2'h2;
	localparam logic [1:0] LEN_THREE = 2'h3;

	typedef enum logic [3:0] {
		CL_PLAIN, CL_COND, CL_PAGE_JUMP, CL_PAGE_CALL, CL_FAR_JUMP, CL_FAR_CALL, CL_RETURN,
		CL_SHORT, CL_PTR_JUMP, CL_CODE_READ, CL_EXT_MOVE, CL_LOAD_PTR, CL_PUSH, CL_POP,
		CL_NIBBLE
	} cit_class_type;

	typedef struct packed {
		logic [1:0] len;
		logic [2:0] cyc;
		cit_class_type cls;
	} cit_decode_type;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] op1;
		logic [7:0] op2;
	} cit_instr_type;

	typedef struct packed {
		logic code_rd;
		logic xdata_rd;
		logic xdata_wr;
		logic [15:0] addr;
	} cit_mem_type;

	// Byte length, not-taken cycle count and class of each opcode
	function automatic cit_decode_type cit_decode(input logic [7:0] opc);
		cit_decode_type d;
		d = '{len: LEN_ONE, cyc: 3'h1, cls: CL_PLAIN};
		casez (opc)
			OP_NOP, OP_UNUSED: d = '{len: LEN_ONE, cyc: 3'h1, cls: CL_PLAIN};
			OP_PAGE_JUMP: d = '{len: LEN_TWO, cyc: 3'h3, cls: CL_PAGE_JUMP};
			OP_PAGE_CALL: d = '{len: LEN_TWO, cyc: 3'h3, cls: CL_PAGE_CALL};
			OP_FAR_JUMP: d = '{len: LEN_THREE, cyc: 3'h4, cls: CL_FAR_JUMP};
			OP_FAR_CALL: d = '{len: LEN_THREE, cyc: 3'h4, cls: CL_FAR_CALL};
			OP_SUB_RETURN, OP_INT_RETURN: d = '{len: LEN_ONE, cyc: 3'h5, cls: CL_RETURN};
			OP_SHORT_JUMP: d = '{len: LEN_TWO, cyc: 3'h3, cls: CL_SHORT};
			OP_PTR_JUMP: d = '{len: LEN_ONE, cyc: 3'h3, cls: CL_PTR_JUMP};
			OP_JUMP_CARRY, OP_JUMP_NO_CARRY, OP_JUMP_ZERO, OP_JUMP_NONZERO, OP_DEC_REG:
				d = '{len: LEN_TWO, cyc: 3'h2, cls: CL_COND};
			OP_JUMP_BIT, OP_JUMP_NO_BIT, OP_BIT_TEST_CLEAR, OP_CMP_ACC_IMM, OP_CMP_REG_IMM,
			OP_DEC_DIRECT:
				d = '{len: LEN_THREE, cyc: 3'h3, cls: CL_COND};
			OP_CMP_ACC_DIRECT, OP_CMP_IND_IMM0, OP_CMP_IND_IMM1:
				d = '{len: LEN_THREE, cyc: 3'h4, cls: CL_COND};
			OP_CODE_READ_PTR, OP_CODE_READ_PC: d = '{len: LEN_ONE, cyc: 3'h3, cls: CL_CODE_READ};
			OP_XRD_PTR, OP_XWR_PTR, OP_XRD_IND0, OP_XRD_IND1, OP_XWR_IND0, OP_XWR_IND1:
				d = '{len: LEN_ONE, cyc: 3'h3, cls: CL_EXT_MOVE};
			OP_LOAD_POINTER: d = '{len: LEN_THREE, cyc: 3'h3, cls: CL_LOAD_PTR};
			OP_MOVE_DIR_DIR: d = '{len: LEN_THREE, cyc: 3'h3, cls: CL_PLAIN};
			OP_PUSH: d = '{len: LEN_TWO, cyc: 3'h2, cls: CL_PUSH};
			OP_POP: d = '{len: LEN_TWO, cyc: 3'h2, cls: CL_POP};
			OP_NIBBLE_X0, OP_NIBBLE_X1: d = '{len: LEN_ONE, cyc: 3'h2, cls: CL_NIBBLE};
			OP_IND_ACC_MOVE: d = '{len: LEN_ONE, cyc: 3'h2, cls: CL_PLAIN};
			OP_BIT_OR, OP_BIT_OP: d = '{len: LEN_TWO, cyc: 3'h2, cls: CL_PLAIN};
			OP_ACC_SINGLE, OP_CARRY_SINGLE, OP_ROTATE: d = '{len: LEN_ONE, cyc: 3'h1, cls: CL_PLAIN};
			default: d = '{len: LEN_ONE, cyc: 3'h1, cls: CL_PLAIN};
		endcase
		return d;
	endfunction
endpackage

// >>> sim/cit_mem_model.sv
// Program and external data memory model that logs core access requests
`timescale 1ns/100ps
module cit_mem_model
	import cit_pkg::*;
(
	input wire logic clock, // System clock
	input wire logic rst_b, // Reset, active low
	input wire cit_mem_type mem_req, // Access request from the core
	output logic [1:0] last_kind, // 1 code read, 2 data read, 3 data write
	output logic [15:0] last_addr, // Address of the last access
	output logic [7:0] n_access // Accesses seen since reset
);
	// Take each one-cycle request with its full 16-bit address
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			last_kind <= 2'h0;
			last_addr <= 16'h0000;
			n_access <= 8'h00;
		end
		else if (mem_req.code_rd | mem_req.xdata_rd | mem_req.xdata_wr)
		begin
			last_addr <= mem_req.addr;
			last_kind <= mem_req.code_rd ? 2'h1 : (mem_req.xdata_rd ? 2'h2 : 2'h3);
			n_access <= n_access + 8'h01;
		end
	end
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the instruction timing unit
`timescale 1ns/100ps
module testbench
	import cit_pkg::*;
;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic instr_valid = 1'b0;
	cit_instr_type instr = '0;
	logic [7:0] acc_value = 8'h00, operand_value = 8'h00, sfr_addr = 8'h00, sfr_wdata = 8'h00;
	logic carry_flag = 1'b0, bit_value = 1'b0, sfr_wr = 1'b0;
	logic [1:0] bank_select = 2'h0;
	logic [15:0] return_addr = 16'h0000;
	logic instr_ready, dir_is_sfr, done, branch_taken, stack_wr, stack_rd, bit_clear;
	logic [7:0] sfr_rdata, stack_addr, stack_pointer, dec_result, nibble_ram, nibble_acc;
	logic [4:0] reg_addr;
	logic [6:0] ram_addr;
	logic [15:0] fetch_addr, wide_pointer, last_addr, s_fa;
	cit_mem_type mem_req, s_mem;
	logic [1:0] last_kind;
	logic [7:0] n_access, s_sa;
	logic s_sw, s_bc, s_sr;
	int num_errors = 0, n_compared = 0;

	// 25 MHz clock
	always #20 clock = ~clock;

	cit_instruction_timing u_dut (.clock(clock), .rst_b(rst_b), .instr_valid(instr_valid),
		.instr(instr), .instr_ready(instr_ready), .acc_value(acc_value), .carry_flag(carry_flag),
		.bit_value(bit_value), .operand_value(operand_value), .bank_select(bank_select),
		.return_addr(return_addr), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .reg_addr(reg_addr), .dir_is_sfr(dir_is_sfr), .ram_addr(ram_addr),
		.fetch_addr(fetch_addr), .done(done), .branch_taken(branch_taken), .mem_req(mem_req),
		.stack_wr(stack_wr), .stack_rd(stack_rd), .stack_addr(stack_addr),
		.stack_pointer(stack_pointer), .bit_clear(bit_clear), .dec_result(dec_result),
		.nibble_ram(nibble_ram), .nibble_acc(nibble_acc), .wide_pointer(wide_pointer));

	cit_mem_model u_mem (.clock(clock), .rst_b(rst_b), .mem_req(mem_req),
		.last_kind(last_kind), .last_addr(last_addr), .n_access(n_access));

	// Report counts and verdict, then end the run
	task automatic stop_test();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Compare one value
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Step to just after the next rising edge
	task automatic tick();
		@(posedge clock);
		#1;
	endtask

	// Issue one instruction and time it from accept to retire
	task automatic run(input logic [23:0] ins, input logic [15:0] cyc);
		logic [15:0] n;
		n = 16'h0000;
		instr = ins;
		instr_valid = 1'b1;
		tick();
		instr_valid = 1'b0;
		s_mem = mem_req;
		s_sw = stack_wr;
		s_sr = stack_rd;
		s_sa = stack_addr;
		s_bc = bit_clear;
		s_fa = fetch_addr;
		while (done !== 1'b1 && n < 16'h000c)
		begin
			tick();
			n++;
		end
		if (n == 16'h000c)
		begin
			num_errors++;
			stop_test();
		end
		check(n, cyc);
	endtask

	// Registers hold full bytes only; no reserved bits are set
	task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
		sfr_wr = 1'b1;
		sfr_addr = a;
		sfr_wdata = d;
		tick();
		sfr_wr = 1'b0;
		tick(); // An idle edge keeps back-to-back writes from re-raising the strobe at once
	endtask

	// Read a special register one cycle after its address is shown
	task automatic sfr_r(input logic [7:0] a, input logic [7:0] exp);
		sfr_addr = a;
		tick();
		check({8'h00, sfr_rdata}, {8'h00, exp});
	endtask

	// Reset values, pointer byte writes and an unmapped address
	task automatic t_regs();
		sfr_r(ADDR_PTR_LOW, 8'h00);
		sfr_r(ADDR_PTR_HIGH, 8'h00);
		sfr_r(ADDR_STACK, 8'h07);
		sfr_w(ADDR_PTR_LOW, 8'h34);
		sfr_w(ADDR_PTR_HIGH, 8'h12);
		check(wide_pointer, 16'h1234);
		sfr_r(ADDR_PTR_HIGH, 8'h12);
		sfr_w(8'h90, 8'h55);
		sfr_r(8'h90, 8'h00);
	endtask

	// Length and cycles of fixed-time instructions: {opcode, length, cycles}
	task automatic t_table();
		logic [15:0] t [26] = '{16'h0011, 16'ha511, 16'he411, 16'hf411, 16'h2311, 16'h3311,
			16'h0311, 16'h1311, 16'hc411, 16'hc311, 16'hd311, 16'hb311, 16'h8533, 16'he612,
			16'hd612, 16'hc022, 16'hd022, 16'h9222, 16'h7222, 16'ha222, 16'h9313, 16'h8313,
			16'he013, 16'hf013, 16'he213, 16'h9033};
		logic [15:0] p;
		for (int i = 0; i < 26; i++)
		begin
			p = fetch_addr;
			run({t[i][15:8], 16'h0000}, {12'h000, t[i][3:0]});
			check(s_fa, p + t[i][7:4]);
		end
	endtask

	// Conditional jump with given operands and expected timing
	task automatic cond(input logic [23:0] ins, input logic [7:0] a, input logic c, b,
		input logic [7:0] v, input logic [15:0] n, input logic tk, input logic [2:0] ln);
		logic [15:0] p;
		logic [7:0] r;
		p = fetch_addr;
		r = (ln == 3'h3) ? ins[7:0] : ins[15:8];
		acc_value = a;
		carry_flag = c;
		bit_value = b;
		operand_value = v;
		run(ins, n);
		check({15'h0000, branch_taken}, {15'h0000, tk});
		check(s_fa, p + ln + (tk ? {{8{r[7]}}, r} : 16'h0000));
	endtask

	// Taken and untaken conditional jumps, negative and positive offsets
	task automatic t_branch();
		cond(24'h40fe00, 8'h00, 1, 0, 8'h00, 3, 1, 2);
		cond(24'h40fe00, 8'h00, 0, 0, 8'h00, 2, 0, 2);
		cond(24'h501000, 8'h00, 0, 0, 8'h00, 3, 1, 2);
		cond(24'h608000, 8'h00, 0, 0, 8'h00, 3, 1, 2);
		cond(24'h700400, 8'h00, 0, 0, 8'h00, 2, 0, 2);
		cond(24'h2021f0, 8'h00, 0, 1, 8'h00, 4, 1, 3);
		cond(24'h302107, 8'h00, 0, 1, 8'h00, 3, 0, 3);
		cond(24'h102110, 8'h00, 0, 1, 8'h00, 4, 1, 3);
		check({15'h0000, s_bc}, 16'h0001);
		cond(24'h102110, 8'h00, 0, 0, 8'h00, 3, 0, 3);
		check({15'h0000, s_bc}, 16'h0000);
		cond(24'hb53009, 8'h05, 0, 0, 8'h05, 4, 0, 3);
		cond(24'hb53009, 8'h05, 0, 0, 8'h06, 5, 1, 3);
		cond(24'hb40509, 8'h05, 0, 0, 8'h00, 3, 0, 3);
		cond(24'hb406f9, 8'h05, 0, 0, 8'h00, 4, 1, 3);
		cond(24'hba0909, 8'h00, 0, 0, 8'h07, 4, 1, 3);
		cond(24'hb60309, 8'h00, 0, 0, 8'h03, 4, 0, 3);
		cond(24'hd80600, 8'h00, 0, 0, 8'h01, 2, 0, 2);
		cond(24'hd80600, 8'h00, 0, 0, 8'h02, 3, 1, 2);
		cond(24'hd54006, 8'h00, 0, 0, 8'h00, 4, 1, 3);
		check({8'h00, dec_result}, 16'h00ff);
	endtask

	// Unconditional flow changes, page boundary, calls, returns and stack
	task automatic t_flow();
		logic [7:0] sp;
		run(24'h021ffe, 4);
		check(s_fa, 16'h1ffe);
		run(24'h0207fe, 4);
		run(24'he15500, 3);
		check(s_fa, 16'h0f55);
		run(24'h800500, 3);
		check(s_fa, 16'h0f5c);
		sp = stack_pointer;
		run(24'h121234, 4);
		check({8'h00, stack_pointer}, {8'h00, sp + 8'h02});
		run(24'h114400, 3);
		return_addr = 16'h0abc;
		run(24'h220000, 5);
		check(s_fa, 16'h0abc);
		run(24'h320000, 5);
		sp = stack_pointer;
		run(24'hc03000, 2);
		check({15'h0000, s_sw}, 16'h0001);
		check({8'h00, s_sa}, {8'h00, sp + 8'h01});
		run(24'hd03000, 2);
		check({14'h0000, s_sr, s_sw}, 16'h0002);
		check({8'h00, s_sa}, {8'h00, sp + 8'h01});
		sfr_w(ADDR_PTR_HIGH, 8'h12);
		sfr_w(ADDR_PTR_LOW, 8'h34);
		acc_value = 8'h10;
		run(24'h730000, 3);
		check(s_fa, 16'h1244);
	endtask

	// Code and external data accesses seen by the memory model
	task automatic t_mem();
		run(24'h930000, 3);
		check({14'h0000, last_kind}, 16'h0001);
		check(last_addr, 16'h1244);
		operand_value = 8'h5a;
		run(24'he20000, 3);
		check(last_addr, 16'h005a);
		run(24'hf00000, 3);
		check({14'h0000, last_kind}, 16'h0003);
		check(last_addr, 16'h1234);
		check({13'h0000, s_mem.code_rd, s_mem.xdata_rd, s_mem.xdata_wr}, 16'h0001);
		check({8'h00, n_access}, 16'h0008);
		run(24'h90abcd, 3);
		check(wide_pointer, 16'habcd);
		sfr_r(ADDR_PTR_LOW, 8'hcd);
		acc_value = 8'h5a;
		operand_value = 8'hc3;
		run(24'hd70000, 2);
		check({nibble_ram, nibble_acc}, 16'hca53);
	endtask

	// Second instruction offered while the first is busy enters in its last cycle
	task automatic t_pipe();
		logic [15:0] p;
		p = fetch_addr;
		instr = 24'h800000;
		instr_valid = 1'b1;
		tick();
		instr = 24'h000000;
		check({15'h0000, instr_ready}, 16'h0000);
		tick();
		tick();
		check({15'h0000, instr_ready}, 16'h0001);
		tick();
		instr_valid = 1'b0;
		check({15'h0000, done}, 16'h0001);
		check(fetch_addr, p + 16'h0003);
		tick();
		check({15'h0000, done}, 16'h0001);
	endtask

	// Operand decode of bank registers and direct addresses
	task automatic t_decode();
		bank_select = 2'h2;
		instr = 24'he97f00;
		tick();
		check({11'h000, reg_addr}, 16'h0011);
		check({8'h00, dir_is_sfr, ram_addr}, 16'h007f);
		instr = 24'he78000;
		tick();
		check({11'h000, reg_addr}, 16'h0011);
		check({8'h00, dir_is_sfr, ram_addr}, 16'h0080);
	endtask

	// Reset, then all scenarios
	initial
	begin
		repeat (12) @(posedge clock);
		#1;
		rst_b = 1'b1;
		repeat (3) tick();
		t_regs();
		t_table();
		t_branch();
		t_flow();
		t_mem();
		t_pipe();
		t_decode();
		stop_test();
	end
endmodule
